// [fses_flash_seq.sv]
// Flash sector erase and byte program sequencer
// Operation
// - Flash is 384 sectors of 128 bytes, sector n at byte n*128.
// - User mode erases whole sectors only.
// - No sector erase while in tool program mode.
// - Commands accepted only while unlock register holds 10100101b.
// - Command 10100001b while unlocked erases the selected sector.
// - Command 01010001b arms programming; next store writes one byte.
// - Programming writes exactly one byte per operation.
// - Erase failure sets control bit 3; software retries.
// - Enabled unmasked interrupt may stop an erase in progress.
// - High register gives address 15..8, low bit 7 gives bit 7.
// - Enabled boot area refuses user erase and program.
`timescale 1ns/1ps
`default_nettype none
module fses_flash_seq
	import fses_pkg::*;
#(
	parameter int unsigned ERASE_CNT = ERASE_CYCLES,
	parameter int unsigned ADDR_BITS = ADDR_W
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic unlock_wr,
	input wire logic [7:0] unlock_wdata,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic sech_wr,
	input wire logic secl_wr,
	input wire logic [7:0] sec_wdata,
	input wire logic store_req,
	input wire logic load_req,
	input wire logic [ADDR_BITS-1:0] mem_addr,
	input wire logic [7:0] store_data,
	input wire logic irq_pending,
	input wire logic tool_mode,
	input wire logic boot_area_en,
	input wire logic [ADDR_BITS-1:0] boot_area_size,
	input wire logic array_fail,
	output logic [7:0] unlock_rdata,
	output logic [7:0] ctrl_rdata,
	output logic [7:0] sech_rdata,
	output logic [7:0] secl_rdata,
	output logic load_stall,
	output logic busy,
	output logic arr_erase,
	output logic arr_prog,
	output logic [ADDR_BITS-1:0] arr_addr,
	output logic [7:0] arr_wdata
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ERASE = 3'b010,
		ST_PROG = 3'b100
	} fses_state_t;

	typedef struct packed {
		fses_state_t st;
		logic [7:0] unlock;
		logic [7:0] sech;
		logic sec7;
		logic armed;
		logic fail;
		logic [31:0] cnt;
		logic [ADDR_BITS-1:0] addr;
		logic [7:0] wdata;
	} fses_regs_t;

	fses_regs_t regs_ff;
	fses_regs_t nxt_regs;

	logic key_ok;
	logic [ADDR_BITS-1:0] sec_base;
	logic [ADDR_BITS:0] boot_end;
	logic sec_in_boot;
	logic mem_in_boot;
	logic sec_in_range;
	logic mem_in_range;
	logic mem_same_sec;
	logic erase_ok;
	logic prog_arm_ok;
	logic store_take;
	logic store_ok;
	logic erase_abort;
	logic erase_last;
	logic prog_last;

	// All registers but the state clear to zero; the state loads ST_IDLE
	localparam fses_regs_t REGS_RESET = '{
		st: ST_IDLE,
		unlock: REG_RESET,
		sech: REG_RESET,
		sec7: 1'b0,
		armed: 1'b0,
		fail: 1'b0,
		cnt: 32'd0,
		addr: '0,
		wdata: REG_RESET
	};

	assign key_ok = (regs_ff.unlock == UNLOCK_KEY);
	// Low register bits 6..0 are never stored
	assign sec_base = {regs_ff.sech, regs_ff.sec7, 7'd0};

	// Window end one bit wider so a window at the top cannot wrap
	assign boot_end = {1'b0, ADDR_BITS'(BOOT_BASE)} + {1'b0, boot_area_size};
	assign sec_in_boot = boot_area_en && (sec_base >= ADDR_BITS'(BOOT_BASE))
		&& ({1'b0, sec_base} < boot_end);
	assign mem_in_boot = boot_area_en && (mem_addr >= ADDR_BITS'(BOOT_BASE))
		&& ({1'b0, mem_addr} < boot_end);

	assign sec_in_range = (sec_base <= FLASH_TOP);
	assign mem_in_range = (mem_addr <= FLASH_TOP);
	// Store must fall inside the sector the registers name
	assign mem_same_sec = (mem_addr[ADDR_BITS-1:7] == sec_base[ADDR_BITS-1:7]);

	// Erase only a whole, reachable, unprotected sector
	assign erase_ok = key_ok && (ctrl_wdata == CMD_ERASE) && !tool_mode
		&& !sec_in_boot && sec_in_range;
	assign prog_arm_ok = key_ok && (ctrl_wdata == CMD_PROGRAM);
	// Key re-checked at the store in case it was cleared early
	assign store_take = store_req && regs_ff.armed;
	assign store_ok = key_ok && !mem_in_boot && mem_in_range && mem_same_sec;
	// Any pending enabled interrupt ends the erase at once
	assign erase_abort = irq_pending;

	// Counters compare at full width; parameters cast once here
	assign erase_last = (regs_ff.cnt == 32'(ERASE_CNT - 1));
	assign prog_last = (regs_ff.cnt == 32'(PROG_CYCLES - 1));

	// Next state: register writes first, then the sequencer step
	always_comb begin
		// Hold everything unless a write or the sequencer moves it
		nxt_regs = regs_ff;
		// Unlock and sector register writes land in any state, even mid-erase
		if (unlock_wr) begin
			nxt_regs.unlock = unlock_wdata;
		end
		if (sech_wr) begin
			nxt_regs.sech = sec_wdata;
		end
		if (secl_wr) begin
			nxt_regs.sec7 = sec_wdata[7];
		end
		unique case (regs_ff.st)
			// Commands and stores only act while idle
			ST_IDLE: begin
				if (ctrl_wr) begin
					nxt_regs.armed = 1'b0;
					// Bad key or unknown code drops the write but still clears armed
					if (erase_ok) begin
						nxt_regs.st = ST_ERASE;
						nxt_regs.addr = sec_base;
						nxt_regs.cnt = 32'd0;
						nxt_regs.fail = 1'b0;
					end else if (prog_arm_ok) begin
						nxt_regs.armed = 1'b1;
					end
				end else if (store_take) begin
					nxt_regs.armed = 1'b0;
					if (store_ok) begin
						nxt_regs.st = ST_PROG;
						nxt_regs.addr = mem_addr;
						nxt_regs.wdata = store_data;
						nxt_regs.cnt = 32'd0;
					end
				end
			end
			ST_ERASE: begin
				nxt_regs.cnt = regs_ff.cnt + 32'd1;
				// Failure is sticky until the next accepted erase
				if (array_fail) begin
					nxt_regs.fail = 1'b1;
				end
				if (erase_abort) begin
					// Aborted erase leaves the sector unknown, so flag failure
					nxt_regs.st = ST_IDLE;
					nxt_regs.fail = 1'b1;
				end else if (erase_last) begin
					nxt_regs.st = ST_IDLE;
				end
			end
			// Byte program runs a fixed count with no abort path
			ST_PROG: begin
				nxt_regs.cnt = regs_ff.cnt + 32'd1;
				if (prog_last) begin
					nxt_regs.st = ST_IDLE;
				end
			end
		endcase
	end

	// Reset branch loads constants only
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			regs_ff <= REGS_RESET;
		end else begin
			regs_ff <= nxt_regs;
		end
	end

	// Outputs other than load_stall straight from the state flops, so the array sees clean levels
	assign unlock_rdata = regs_ff.unlock;
	assign ctrl_rdata = (regs_ff.fail ? FAIL_MASK : 8'h00) | {7'h00, regs_ff.st == ST_ERASE};
	assign sech_rdata = regs_ff.sech;
	assign secl_rdata = {regs_ff.sec7, 7'd0};

	assign busy = (regs_ff.st != ST_IDLE);
	assign load_stall = load_req && (regs_ff.st == ST_ERASE);

	assign arr_erase = (regs_ff.st == ST_ERASE);
	assign arr_prog = (regs_ff.st == ST_PROG);
	assign arr_addr = regs_ff.addr;
	assign arr_wdata = regs_ff.wdata;
endmodule // fses_flash_seq
`default_nettype wire

// [fses_pkg.sv]
// Package of constants for the flash sector erase and program sequencer
package fses_pkg;
	localparam int unsigned SECTOR_COUNT = 384;
	localparam int unsigned SECTOR_BYTES = 128;
	localparam logic [7:0] UNLOCK_KEY = 8'h00_A5;
	localparam logic [7:0] CMD_ERASE = 8'h00_A1;
	localparam logic [7:0] CMD_PROGRAM = 8'h00_51;
	localparam int unsigned FAIL_BIT_POS = 3;
	localparam logic [7:0] FAIL_MASK = 8'h00_08;
	localparam logic [7:0] REG_RESET = 8'h00_00;
	localparam logic [15:0] BOOT_BASE = 16'h0100;
	localparam int unsigned CLK_HZ = 20_000_000;
	// Erase pulse length on the array side, in microseconds
	localparam int unsigned ERASE_US = 10_000;
	localparam int unsigned ERASE_CYCLES = ERASE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned PROG_CYCLES = 4;
	localparam int unsigned ADDR_W = 16;
	localparam logic [ADDR_W-1:0] FLASH_TOP = 16'hBFFF;
endpackage

// [fses_flash_seq_asserts.sv]
// Port assertions for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fses_flash_seq_asserts
	import fses_pkg::*;
#(
	parameter int unsigned ERASE_CNT = 20,
	parameter int unsigned ADDR_BITS = 16
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ctrl_wr,
	input wire logic tool_mode,
	input wire logic boot_area_en,
	input wire logic irq_pending,
	input wire logic load_req,
	input wire logic [7:0] ctrl_wdata,
	input wire logic [7:0] unlock_rdata,
	input wire logic [7:0] ctrl_rdata,
	input wire logic [7:0] sech_rdata,
	input wire logic [7:0] secl_rdata,
	input wire logic load_stall,
	input wire logic busy,
	input wire logic arr_erase,
	input wire logic arr_prog,
	input wire logic [ADDR_BITS-1:0] arr_addr
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_erase_start:
	assert property (ctrl_wr && ctrl_wdata == CMD_ERASE && unlock_rdata == UNLOCK_KEY && !busy
		&& !tool_mode && !boot_area_en && !irq_pending && sech_rdata < 8'h00_C0 |=> arr_erase)
		else $error("erase not started");
	a_key_needed:
	assert property (ctrl_wr && unlock_rdata != UNLOCK_KEY && !busy |=> !arr_erase && !arr_prog)
		else $error("command taken without key");
	a_tool_block:
	assert property (tool_mode && !busy |=> !arr_erase) else $error("erase in tool mode");
	a_erase_addr:
	assert property ($rose(arr_erase) |-> arr_addr == {sech_rdata, secl_rdata[7], 7'h00})
		else $error("wrong erase address");
	a_prog_bytes:
	assert property ($rose(arr_prog) |-> arr_prog[*4] ##1 !arr_prog) else $error("program length");
	a_irq_abort:
	assert property (arr_erase && irq_pending |-> ##[1:2] !arr_erase) else $error("erase not stopped");
	a_load_stall:
	assert property (load_req && arr_erase |-> load_stall) else $error("load not stalled");
	a_erase_status:
	assert property ($rose(arr_erase) |-> ctrl_rdata[0] && !ctrl_rdata[3]) else $error("erase status");
endmodule // fses_flash_seq_asserts
bind fses_flash_seq fses_flash_seq_asserts #(.ERASE_CNT(ERASE_CNT), .ADDR_BITS(ADDR_BITS))
	i_fses_flash_seq_asserts (.*);
`default_nettype wire

// [fses_cpu_model.sv]
// Processor side model issuing register writes and program stores
`timescale 1ns/1ps
`default_nettype none
module fses_cpu_model
	import fses_pkg::*;
(
	input wire logic clk_sys,
	output logic [4:0] stb = 5'h00,
	output logic [7:0] wd = 8'h00_00,
	output logic [15:0] ad = 16'h0000
);
	task automatic w(input int k, input logic [7:0] d);
		@(negedge clk_sys);
		stb[k] = 1'b1;
		wd = d;
		@(negedge clk_sys);
		stb = 5'h00;
		wd = ~d; // Released bus must not show stale data
	endtask
	task automatic erase(input logic [7:0] key, hi, lo);
		w(0, key);
		w(2, hi);
		w(3, lo);
		w(1, CMD_ERASE);
		repeat (2) @(negedge clk_sys);
		w(0, 8'h00_00);
	endtask
	task automatic prog(input logic [15:0] a, input logic [7:0] d);
		ad = a;
		w(0, UNLOCK_KEY);
		w(2, a[15:8]);
		w(3, {a[7], 7'h00});
		w(1, CMD_PROGRAM);
		w(4, d);
		@(negedge clk_sys);
		w(0, 8'h00_00);
	endtask
endmodule // fses_cpu_model
`default_nettype wire

// [tb_flash_sector_erase_program.sv]
// Testbench for the flash sector erase and program sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_flash_sector_erase_program
	import fses_pkg::*;
;
	logic clk_sys = 0, resetn = 0, load_req = 0, irq_pending = 0, tool_mode = 0, boot_area_en = 0;
	logic array_fail = 0, load_stall, busy, arr_erase, arr_prog;
	logic [4:0] stb;
	logic [7:0] wd, ctrl_rdata, arr_wdata, unlock_rd, sech_rd, secl_rd;
	logic [15:0] ad, arr_addr, eaddr = 0;
	logic [23:0] pcap = 0;
	int error_cnt = 0, checked = 0, ecyc = 0, pcyc = 0, cyc = 0;
	fses_cpu_model i_fses_cpu_model (.clk_sys(clk_sys), .stb(stb), .wd(wd), .ad(ad));
	fses_flash_seq #(.ERASE_CNT(20)) i_fses_flash_seq (.clk_sys(clk_sys), .resetn(resetn),
		.unlock_wr(stb[0]), .unlock_wdata(wd), .ctrl_wr(stb[1]), .ctrl_wdata(wd),
		.sech_wr(stb[2]), .secl_wr(stb[3]), .sec_wdata(wd), .store_req(stb[4]), .load_req(load_req),
		.mem_addr(ad), .store_data(wd), .irq_pending(irq_pending), .tool_mode(tool_mode),
		.boot_area_en(boot_area_en), .boot_area_size(16'h0100), .array_fail(array_fail),
		.unlock_rdata(unlock_rd), .ctrl_rdata(ctrl_rdata), .sech_rdata(sech_rd),
		.secl_rdata(secl_rd),
		.load_stall(load_stall), .busy(busy), .arr_erase(arr_erase), .arr_prog(arr_prog),
		.arr_addr(arr_addr), .arr_wdata(arr_wdata));
	initial forever #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (arr_erase) ecyc <= ecyc + 1;
		if (arr_erase) eaddr <= arr_addr;
		if (arr_prog) pcyc <= pcyc + 1;
		if (arr_prog) pcap <= {arr_addr, arr_wdata};
		if (cyc == 5000) begin
			error_cnt++;
			summarize();
		end
	end
	task automatic chk(input string n, input logic [23:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic settle();
		for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk_sys);
	endtask
	task automatic t_erase(input logic fail, irq, tool, boot, input logic [7:0] key, hi, input int n);
		ecyc = 0;
		array_fail = fail;
		tool_mode = tool;
		boot_area_en = boot;
		i_fses_cpu_model.erase(key, hi, 8'h00_FF);
		if (irq) begin
			load_req = 1;
			#1 chk("stall", load_stall, 1);
			irq_pending = 1;
		end
		settle();
		if (irq) chk("abort", ecyc > 0 && ecyc < 20, 1);
		else chk("length", ecyc, n);
		if (n > 0) chk("fail bit", ctrl_rdata[3], fail | irq);
		if (n > 0) chk("address", eaddr, {hi, 8'h80});
		chk("sector regs", {unlock_rd, sech_rd, secl_rd}, {8'h00, hi, 8'h80});
		{irq_pending, load_req, tool_mode, boot_area_en} = 0;
		$display("erase test done");
	endtask
	task automatic t_prog();
		pcyc = 0;
		i_fses_cpu_model.prog(16'h10C4, 8'h00_78);
		settle();
		chk("prog length", pcyc, 4);
		chk("prog target", pcap, 24'h10_C478);
		$display("program test done");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clk_sys);
		resetn = 1;
		t_erase(0, 0, 0, 0, UNLOCK_KEY, 8'h00_10, 20);
		t_erase(1, 0, 0, 0, UNLOCK_KEY, 8'h00_10, 20);
		t_erase(0, 0, 1, 0, UNLOCK_KEY, 8'h00_10, 0);
		t_erase(0, 0, 0, 1, UNLOCK_KEY, 8'h00_01, 0);
		t_erase(0, 0, 0, 0, 8'h00_5A, 8'h00_10, 0);
		t_erase(0, 0, 0, 0, UNLOCK_KEY, 8'h00_C0, 0);
		t_erase(0, 1, 0, 0, UNLOCK_KEY, 8'h00_10, 1);
		t_erase(0, 0, 0, 0, UNLOCK_KEY, 8'h00_10, 20);
		t_prog();
		summarize();
	end
endmodule // tb_flash_sector_erase_program
`default_nettype wire
